/* design/io_expander.sv */
// sixteen bit io expander behind a two-wire serial target interface
`timescale 1ns/1ps
module io_expander import io_expander_pkg::*; #(
	parameter bit RETAIN_REGS = 1'b0,
	parameter logic [4:0] ADDR_FIXED = ADDR_FIXED_DEF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic rst_pin_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_sel_lo,
	input wire logic addr_sel_hi,
	input wire logic [IO_W-1:0] io_in,
	output logic [IO_W-1:0] io_out,
	output logic [IO_W-1:0] io_oe,
	output logic int_out,
	output logic int_oe
);

core_t st_reg;
core_t st_next;
logic scl_rise;
logic scl_fall;
logic start_c;
logic stop_c;
logic do_load;
logic [PORT_W-1:0] rd_byte;
int pbase;

////////////////////////////////////////////////////////////////////////////////
always_comb begin
	st_next = st_reg;
	do_load = 1'b0;
	pbase = int'(st_reg.ptr[0]) * PORT_W;

	// synchronisers; the filter reads only the second stage
	st_next.line_s1 = {sda_in, scl_in};
	st_next.line_s2 = st_reg.line_s1;
	st_next.pin_s1 = io_in;
	st_next.pin_s2 = st_reg.pin_s1;
	st_next.asel_s1 = {addr_sel_hi, addr_sel_lo};
	st_next.asel_s2 = st_reg.asel_s1;
	st_next.rstp_s1 = rst_pin_n;
	st_next.rstp_s2 = st_reg.rstp_s1;

	// a new level is accepted only after FILT_CYC + 1 equal samples, so a spike caught by one sample vanishes
	for (int i = 0; i < 2; i++) begin
		if (st_reg.line_s2[i] == st_reg.line_f[i]) begin
			st_next.line_cnt[i] = '0;
		end else if (st_reg.line_cnt[i] >= FCW'(FILT_CYC)) begin
			st_next.line_f[i] = st_reg.line_s2[i];
			st_next.line_cnt[i] = '0;
		end else begin
			st_next.line_cnt[i] = st_reg.line_cnt[i] + 1'b1;
		end
	end

	// edges come from the filtered lines only, so no bit timing is assumed
	scl_rise = ~st_reg.line_f[LINE_SCL] & st_next.line_f[LINE_SCL];
	scl_fall = st_reg.line_f[LINE_SCL] & ~st_next.line_f[LINE_SCL];
	start_c = st_reg.line_f[LINE_SCL] & st_next.line_f[LINE_SCL]
		& st_reg.line_f[LINE_SDA] & ~st_next.line_f[LINE_SDA];
	stop_c = st_reg.line_f[LINE_SCL] & st_next.line_f[LINE_SCL]
		& ~st_reg.line_f[LINE_SDA] & st_next.line_f[LINE_SDA];

	// read data for the current pointer
	case (st_reg.ptr[2:1])
		PAIR_IN: rd_byte = st_reg.pin_s2[pbase +: PORT_W] ^ st_reg.pol_r[pbase +: PORT_W];
		PAIR_OUT: rd_byte = st_reg.out_r[pbase +: PORT_W];
		PAIR_POL: rd_byte = st_reg.pol_r[pbase +: PORT_W];
		PAIR_DIR: rd_byte = st_reg.dir_r[pbase +: PORT_W];
		default: rd_byte = '0;
	endcase

	// input register loads the second pin stage once in_ok is clear; straight after nrst that stage still holds zero, not the pins
	if (!st_reg.in_ok) begin
		st_next.in_r = st_reg.pin_s2;
		st_next.in_ok = 1'b1;
	end

	if (start_c) begin
		st_next.state = S_ADDR;
		st_next.bit_cnt = '0;
		st_next.sda_oe = 1'b0;
	end else if (stop_c) begin
		st_next.state = S_IDLE;
		st_next.sda_oe = 1'b0;
	end else if (scl_rise) begin
		case (st_reg.state)
			S_ADDR, S_WDATA: begin
				st_next.shreg = {st_reg.shreg[6:0], st_reg.line_f[LINE_SDA]};
				st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
			end
			S_RDATA: begin
				st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
			end
			S_RACK: begin
				st_next.acked = ~st_reg.line_f[LINE_SDA];
			end
			default: begin
			end
		endcase
	end else if (scl_fall) begin
		case (st_reg.state)
			S_ADDR: begin
				if (st_reg.bit_cnt == BYTE_BITS) begin
					if (st_reg.shreg[7:1] == {ADDR_FIXED, st_reg.asel_s2}) begin
						st_next.state = S_ACK;
						st_next.sda_oe = 1'b1;
						st_next.rw = st_reg.shreg[0];
						st_next.cmd_phase = ~st_reg.shreg[0];
					end else begin
						st_next.state = S_IGNORE;
					end
				end
			end
			S_WDATA: begin
				if (st_reg.bit_cnt == BYTE_BITS) begin
					st_next.state = S_ACK;
					st_next.sda_oe = 1'b1;
					st_next.cmd_phase = 1'b0;
					if (st_reg.cmd_phase) begin
						st_next.ptr = st_reg.shreg[2:0];
					end else begin
						// writes to the input pair are dropped
						case (st_reg.ptr[2:1])
							PAIR_OUT: st_next.out_r[pbase +: PORT_W] = st_reg.shreg;
							PAIR_POL: st_next.pol_r[pbase +: PORT_W] = st_reg.shreg;
							PAIR_DIR: st_next.dir_r[pbase +: PORT_W] = st_reg.shreg;
							default: begin
							end
						endcase
						st_next.ptr = {st_reg.ptr[2:1], ~st_reg.ptr[0]};
					end
				end
			end
			S_ACK: begin
				st_next.bit_cnt = '0;
				if (st_reg.rw) begin
					st_next.state = S_RDATA;
					do_load = 1'b1;
				end else begin
					st_next.state = S_WDATA;
					st_next.sda_oe = 1'b0;
				end
			end
			S_RDATA: begin
				if (st_reg.bit_cnt == BYTE_BITS) begin
					st_next.state = S_RACK;
					st_next.sda_oe = 1'b0;
				end else begin
					st_next.shreg = {st_reg.shreg[6:0], 1'b0};
					st_next.sda_oe = ~st_reg.shreg[6];
				end
			end
			S_RACK: begin
				if (st_reg.acked) begin
					st_next.state = S_RDATA;
					st_next.bit_cnt = '0;
					do_load = 1'b1;
				end else begin
					st_next.state = S_IGNORE;
				end
			end
			default: begin
			end
		endcase
	end

	// a read of an input port re-arms the change detector for that port
	if (do_load) begin
		st_next.shreg = rd_byte;
		st_next.sda_oe = ~rd_byte[7];
		st_next.ptr = {st_reg.ptr[2:1], ~st_reg.ptr[0]};
		if (st_reg.ptr[2:1] == PAIR_IN) begin
			st_next.in_r[pbase +: PORT_W] = st_reg.pin_s2[pbase +: PORT_W];
		end
	end

	// only pins set as inputs can raise the interrupt
	st_next.int_oe = st_reg.in_ok & (|((st_reg.pin_s2 ^ st_reg.in_r) & st_reg.dir_r));

	// reset pin: the bus side always, registers only in the clearing variant
	if (!st_reg.rstp_s2) begin
		st_next.state = S_IDLE;
		st_next.bit_cnt = '0;
		st_next.sda_oe = 1'b0;
		st_next.ptr = '0;
		if (!RETAIN_REGS) begin
			st_next.out_r = OUT_RST;
			st_next.pol_r = POL_RST;
			st_next.dir_r = DIR_RST;
			st_next.in_ok = 1'b0;
			st_next.int_oe = 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		st_reg <= CORE_RST;
	end else begin
		st_reg <= st_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// open-drain lines only ever pull low
assign sda_out = 1'b0;
assign sda_oe = st_reg.sda_oe;
assign int_out = 1'b0;
assign int_oe = st_reg.int_oe;
assign io_out = st_reg.out_r;
assign io_oe = ~st_reg.dir_r;

endmodule

/* design/io_expander_pkg.sv */
// package: constants and state record for the sixteen bit io expander
package io_expander_pkg;


localparam int PORT_W = 8;
localparam int NUM_PORTS = 2;
localparam int IO_W = PORT_W * NUM_PORTS;

// spike rejection: longest spike rounds down to whole cycles, at least one
localparam int CLK_NS = 50;
localparam int SPIKE_NS = 50;
localparam int FILT_CYC = (SPIKE_NS / CLK_NS < 1) ? 1 : SPIKE_NS / CLK_NS;
localparam int FCW = 2;

localparam int LINE_SCL = 0;
localparam int LINE_SDA = 1;
localparam logic [3:0] BYTE_BITS = 4'h8;

// register pointer: bits 2:1 pick the pair, bit 0 the port
localparam logic [1:0] PAIR_IN = 2'h0;
localparam logic [1:0] PAIR_OUT = 2'h1;
localparam logic [1:0] PAIR_POL = 2'h2;
localparam logic [1:0] PAIR_DIR = 2'h3;

localparam logic [IO_W-1:0] OUT_RST = 16'hFFFF;
localparam logic [IO_W-1:0] POL_RST = 16'h0000;
localparam logic [IO_W-1:0] DIR_RST = 16'hFFFF;
// fixed part of the target address; value is arbitrary
localparam logic [4:0] ADDR_FIXED_DEF = 5'h10;

typedef enum logic [2:0] {
	S_IDLE = 3'h0,
	S_ADDR = 3'h1,
	S_ACK = 3'h3,
	S_WDATA = 3'h2,
	S_RDATA = 3'h6,
	S_RACK = 3'h7,
	S_IGNORE = 3'h5
} bus_state_t;

typedef struct packed {
	logic [1:0] line_s1;
	logic [1:0] line_s2;
	logic [1:0] line_f;
	logic [1:0][FCW-1:0] line_cnt;
	logic [IO_W-1:0] pin_s1;
	logic [IO_W-1:0] pin_s2;
	logic [1:0] asel_s1;
	logic [1:0] asel_s2;
	logic rstp_s1;
	logic rstp_s2;
	bus_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic rw;
	logic cmd_phase;
	logic acked;
	logic [2:0] ptr;
	logic [IO_W-1:0] out_r;
	logic [IO_W-1:0] pol_r;
	logic [IO_W-1:0] dir_r;
	logic [IO_W-1:0] in_r;
	logic in_ok;
	logic sda_oe;
	logic int_oe;
} core_t;

localparam core_t CORE_RST = '{
	state: S_IDLE,
	line_s1: 2'h3,
	line_s2: 2'h3,
	line_f: 2'h3,
	out_r: OUT_RST,
	pol_r: POL_RST,
	dir_r: DIR_RST,
	default: '0
};

endpackage

/* bench/i2c_master_model.sv */
// two-wire bus master model driving the expander's serial pins
`timescale 1ns/1ps
module i2c_master_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
// both lines idle high on their pull-ups; the clock stands still between frames
initial begin
	scl = 1'b1;
	sda_m = 1'b1;
end
//////////
// 400 ns bit, 250 ns low: the target answers 4 cycles after the falling edge
task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
	for (int i = 8; i >= 0; i--) begin
		@(posedge clk) sda_m <= tx[i];
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (2) @(posedge clk);
		rx[i] = sda;
		@(posedge clk) scl <= 1'b0;
	end
endtask
// wait for the target to drop its ack before raising the clock, or it reads a stop
task automatic start();
	@(posedge clk) sda_m <= 1'b1;
	repeat (5) @(posedge clk);
	scl <= 1'b1;
	repeat (3) @(posedge clk);
	sda_m <= 1'b0;
	repeat (3) @(posedge clk);
	scl <= 1'b0;
endtask
task automatic stop();
	@(posedge clk) sda_m <= 1'b0;
	repeat (4) @(posedge clk);
	scl <= 1'b1;
	repeat (3) @(posedge clk);
	sda_m <= 1'b1;
	repeat (4) @(posedge clk);
endtask
// one clock-wide high pulse on the serial clock, short enough to count as a spike
task automatic spike();
	@(posedge clk) scl <= 1'b1;
	@(posedge clk) scl <= 1'b0;
endtask
endmodule

/* bench/io_expander_checker.sv */
// concurrent checks on the expander's pins
`timescale 1ns/1ps
module io_expander_checker import io_expander_pkg::*; #(
	parameter bit RETAIN_REGS = 1'b0
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic rst_pin_n,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic [IO_W-1:0] io_in,
	input wire logic [IO_W-1:0] io_out,
	input wire logic [IO_W-1:0] io_oe,
	input wire logic int_out,
	input wire logic int_oe
);
default clocking cb @(posedge sys_clk);
endclocking
default disable iff (!nrst);
a_int_level_low: assert property (int_out == 1'b0)
	else $error("interrupt level not low");
a_int_on_change: assert property (((io_in ^ $past(io_in)) & ~io_oe) != '0 && !int_oe |-> ##[1:6] int_oe)
	else $error("no interrupt on input change");
a_rst_regs: assert property ((!rst_pin_n)[*4] |-> RETAIN_REGS || (io_oe == '0 && io_out == OUT_RST))
	else $error("reset pin left registers");
a_rst_bus: assert property ((!rst_pin_n)[*4] |-> !sda_oe)
	else $error("bus driven in reset");
a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
	else $error("data moved while clock high");
a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*4])
	else $error("data pull not held");
a_out_on_fall: assert property (rst_pin_n && $changed(io_out) |-> !$past(scl_in, 2))
	else $error("output moved off clock fall");
a_dir_on_fall: assert property (rst_pin_n && $changed(io_oe) |-> !$past(scl_in, 2))
	else $error("direction moved off clock fall");
c_int: cover property ($rose(int_oe));
c_ack: cover property ($rose(sda_oe));
c_dir: cover property ($changed(io_oe));
endmodule
bind io_expander io_expander_checker #(.RETAIN_REGS(RETAIN_REGS)) chk_i (.sys_clk(sys_clk), .nrst(nrst),
	.rst_pin_n(rst_pin_n), .scl_in(scl_in), .sda_oe(sda_oe), .io_in(io_in), .io_out(io_out),
	.io_oe(io_oe), .int_out(int_out), .int_oe(int_oe));

/* bench/tb_io_expander.sv */
// self-checking bench for the io expander
`timescale 1ns/1ps
module tb_io_expander import io_expander_pkg::*;;
logic sys_clk = 1'b0;
logic nrst = 1'b0;
logic rst_pin_n = 1'b1;
logic [1:0] asel = 2'h0;
logic [IO_W-1:0] io_in = 16'h1234;
logic [IO_W-1:0] io_out, io_oe, v;
logic sda_out, sda_oe, int_out, int_oe, scl, sda_m, k;
logic keep_sda_out, keep_sda_oe;
logic [IO_W-1:0] keep_io_out, keep_io_oe;
// second target in the register-retaining variant; its fixed address value is arbitrary
localparam logic [4:0] KEEP_FIXED = 5'h11;
logic [4:0] tgt_fixed = ADDR_FIXED_DEF;
int failures = 0;
int cmp_count = 0;
// wired-and bus: a target pulls only while enabled, otherwise the pull-up wins
wire sda = sda_m & (sda_oe ? sda_out : 1'b1) & (keep_sda_oe ? keep_sda_out : 1'b1);
always #25 sys_clk = ~sys_clk;
i2c_master_model m (.clk(sys_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
io_expander DUT (.sys_clk(sys_clk), .nrst(nrst), .rst_pin_n(rst_pin_n), .scl_in(scl), .sda_in(sda),
	.sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_lo(asel[0]), .addr_sel_hi(asel[1]), .io_in(io_in),
	.io_out(io_out), .io_oe(io_oe), .int_out(int_out), .int_oe(int_oe));
io_expander #(.RETAIN_REGS(1'b1), .ADDR_FIXED(KEEP_FIXED)) dut_keep (.sys_clk(sys_clk), .nrst(nrst),
	.rst_pin_n(rst_pin_n), .scl_in(scl), .sda_in(sda), .sda_out(keep_sda_out), .sda_oe(keep_sda_oe),
	.addr_sel_lo(asel[0]), .addr_sel_hi(asel[1]), .io_in(io_in), .io_out(keep_io_out), .io_oe(keep_io_oe),
	.int_out(), .int_oe());
//////////
task automatic wrap_up();
	$display("compares %0d errors %0d", cmp_count, failures);
	if (failures == 0 && cmp_count > 0) begin
		$display("All checks passed");
	end else begin
		$display("Checks failed");
	end
	$finish;
endtask
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	cmp_count++;
	if (got !== exp) begin
		failures++;
		$display("Error %0t got %h exp %h", $time, got, exp);
	end
endtask
task automatic w(input int n);
	repeat (n) @(posedge sys_clk);
endtask
// opens a frame with a write address and returns the ack bit
task automatic probe(input logic [1:0] s, output logic a);
	logic [8:0] r;
	m.start();
	m.xfer({tgt_fixed, s, 2'h1}, r);
	a = r[0];
endtask
task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b);
	logic [8:0] r;
	probe(asel, k);
	m.xfer({p, 1'b1}, r);
	m.xfer({a, 1'b1}, r);
	m.xfer({b, 1'b1}, r);
	m.stop();
	chk(16'(k), 16'h0000);
endtask
task automatic rd(input logic [7:0] p, output logic [15:0] q);
	logic [8:0] r;
	probe(asel, k);
	m.xfer({p, 1'b1}, r);
	m.start();
	m.xfer({tgt_fixed, asel, 2'h3}, r);
	m.xfer(9'h1FE, r);
	q[7:0] = r[8:1];
	m.xfer(9'h1FF, r);
	q[15:8] = r[8:1];
	m.stop();
endtask
//////////
task automatic t_reset();
	chk(io_oe, 16'h0000);
	chk(io_out, 16'hFFFF);
	rd(8'h06, v);
	chk(v, 16'hFFFF);
	rd(8'h04, v);
	chk(v, 16'h0000);
endtask
task automatic t_write();
	wr(8'h03, 8'hA5, 8'h3C);
	chk(io_out, 16'hA53C);
	wr(8'h06, 8'h00, 8'hF0);
	chk(io_oe, 16'h0FFF);
	rd(8'h02, v);
	chk(v, 16'hA53C);
	rd(8'h06, v);
	chk(v, 16'hF000);
endtask
// a one-sample clock spike between bytes must not shift in an extra bit
task automatic t_spike();
	logic [8:0] r;
	probe(asel, k);
	m.xfer({8'h02, 1'b1}, r);
	m.spike();
	m.xfer({8'h66, 1'b1}, r);
	m.stop();
	chk(16'(k), 16'h0000);
	chk(io_out, 16'hA566);
endtask
task automatic t_polarity();
	wr(8'h04, 8'hFF, 8'h00);
	rd(8'h00, v);
	chk(v, 16'h12CB);
endtask
task automatic t_interrupt();
	io_in <= 16'h0234;
	w(6);
	chk(16'(int_oe), 16'h0001);
	chk(16'(int_out), 16'h0000);
	io_in <= 16'h1234;
	w(6);
	chk(16'(int_oe), 16'h0000);
	io_in <= 16'h0234;
	w(6);
	rd(8'h01, v);
	chk(16'(v[7:0]), 16'h0002);
	chk(16'(int_oe), 16'h0000);
endtask
task automatic t_address();
	for (int i = 0; i < 4; i++) begin
		asel <= 2'(i);
		w(4);
		probe(2'(i), k);
		m.stop();
		chk(16'(k), 16'h0000);
		probe(~2'(i), k);
		m.stop();
		chk(16'(k), 16'h0001);
	end
endtask
task automatic t_rst_pin();
	tgt_fixed = KEEP_FIXED;
	wr(8'h02, 8'h5A, 8'h00);
	wr(8'h06, 8'h0F, 8'h00);
	tgt_fixed = ADDR_FIXED_DEF;
	rst_pin_n <= 1'b0;
	w(4);
	chk(io_oe, 16'h0000);
	chk(io_out, 16'hFFFF);
	chk(keep_io_oe, 16'hFFF0);
	chk(keep_io_out, 16'h005A);
	rst_pin_n <= 1'b1;
	w(5);
	rd(8'h04, v);
	chk(v, 16'h0000);
	tgt_fixed = KEEP_FIXED;
	rd(8'h02, v);
	chk(v, 16'h005A);
	tgt_fixed = ADDR_FIXED_DEF;
endtask
initial begin
	w(5);
	nrst <= 1'b1;
	w(6);
	t_reset();
	t_write();
	t_spike();
	t_polarity();
	t_interrupt();
	t_address();
	t_rst_pin();
	wrap_up();
end
initial begin
	#1000000;
	failures++;
	wrap_up();
end
endmodule
